// *** pei_map.svh ***
// register offsets, field positions and reset values for the protocol error status block
`ifndef PEI_MAP_SVH
`define PEI_MAP_SVH
`define PEI_IDX_STATUS 12'h00E
`define PEI_IDX_CCFC 12'h326
`define PEI_IDX_EHL 12'h328
`define PEI_IDX_ENABLE 12'h00C
`define PEI_IDX_MAXODD 12'h32A
`define PEI_IDX_TIMER0 12'h32C
`define PEI_IDX_TIMER1 12'h32E
`define PEI_IDX_CTRL 12'h330
`define PEI_ADDR_BITS 14
`define PEI_BIT_RX 0
`define PEI_BIT_TX 1
`define PEI_BIT_HIE 2
`define PEI_BIT_FNE 3
`define PEI_BIT_FOV 4
`define PEI_BIT_CYC 5
`define PEI_BIT_TIM0 6
`define PEI_BIT_TIM1 7
`define PEI_BIT_MOC 8
`define PEI_BIT_BGS 9
`define PEI_BIT_SSI 10
`define PEI_BIT_MRC 11
`define PEI_BIT_ELC 12
`define PEI_BIT_MSY 13
`define PEI_BIT_CLR 14
`define PEI_BIT_FAT 15
`define PEI_PERSIST_MASK 16'h000F
`define PEI_STATUS_RST 16'h0000
`define PEI_MAXODD_RST 4'hF
`endif

// *** pei_pkg.sv ***
// types for the protocol error status block
package pei_pkg;
  typedef enum logic [1:0] {
    PEI_GREEN,
    PEI_YELLOW,
    PEI_RED,
    PEI_UNUSED
  } pei_level_e;
  // one cycle-end event from the protocol engine
  typedef struct packed {
    logic cycle_end;
    logic odd_cycle;
    logic missing_offset;
    logic missing_rate;
  } pei_cycle_s;
  // timer setting: cycle base, repetition mask, macrotick offset
  typedef struct packed {
    logic [5:0] base;
    logic [5:0] rep_mask;
    logic [13:0] offset;
  } pei_timer_s;
  typedef enum logic [1:0] {
    PEI_APB_IDLE,
    PEI_APB_ACCESS
  } pei_apb_e;
endpackage

// *** pei_ccf_counter.sv ***
// clock correction failed counter, updated at odd cycle ends
`timescale 1ns/1ps
`include "pei_map.svh"
module pei_ccf_counter import pei_pkg::*; #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // control
  input wire logic enter_active,
  input wire pei_cycle_s cyc,
  input wire logic [WIDTH-1:0] max_count,
  // result
  output logic [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pei_ccf_s;
  pei_ccf_s st_q;
  pei_ccf_s st_d;
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("pei_ccf_counter: bad WIDTH");
  end
  always_comb begin
    st_d = st_q;
    if (enter_active) begin
      st_d.cnt = '0;
    end else if (cyc.cycle_end && cyc.odd_cycle) begin
      if (cyc.missing_offset || cyc.missing_rate) begin
        if (st_q.cnt < max_count) begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end else begin
        st_d.cnt = '0;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
  assign count = st_q.cnt;
endmodule

// *** pei_timer_match.sv ***
// timer flag condition: cycle and macrotick match per timer
`timescale 1ns/1ps
module pei_timer_match import pei_pkg::*; #(
  parameter int NUM = 2
) (
  // timer settings and current time
  input wire pei_timer_s [NUM-1:0] setup,
  input wire logic [5:0] cycle_now,
  input wire logic [13:0] mtick_now,
  // match per timer
  output logic [NUM-1:0] hit
);
  if (NUM < 1) begin : g_bad_num
    $error("pei_timer_match: bad NUM");
  end
  for (genvar i = 0; i < NUM; i++) begin : g_tim
    // repetition mask selects which cycle bits must equal the base
    assign hit[i] = (((cycle_now ^ setup[i].base) & setup[i].rep_mask) == 6'h00)
                    && (mtick_now == setup[i].offset);
  end
endmodule

// *** pei_status.sv ***
// protocol error and main interrupt status block with APB register access
// Operation
// - counter cleared on entering normal active
// - odd cycle end with missing correction increments
// - odd cycle end without failures zeroes counter
// - counter saturates at programmed maximum
// - counter read-only in low four bits
// - two-bit error level green yellow red
// - host clears status by writing one
// - device sets flag again on condition
// - device update wins over host write
// - persistent causes block host clears
// - status cleared on reset, config exit; enables
// - receive flag from enabled receive buffers
// - transmit flag read-only, from empty buffers
// - host interface error sets its flag
// - fifo flag follows fifo and unlocked buffer
// - overrun and cycle start set flags
// - timer flags on cycle and macrotick match
// - timer flags show set after reset while macrotick is 0
// - missing offset flag every cycle end
// - guardian error sets flag, host clears
// - enabled slot counter increment sets flag
// - missing rate flag at odd cycle end
// - illegal state sets fatal, enters red
// - error level change sets flag
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "pei_map.svh"
module pei_status import pei_pkg::*; #(
  parameter int NUM_RX = 8,
  parameter int NUM_TX = 8,
  parameter int NUM_SSC = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PEI_ADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine state
  input wire logic leave_config,
  input wire logic enter_active,
  input wire pei_level_e level_in,
  input wire logic illegal_state,
  input wire pei_cycle_s cyc,
  input wire logic cycle_start,
  input wire logic [5:0] cycle_now,
  input wire logic [13:0] mtick_now,
  input wire logic sync_overflow,
  input wire logic corr_limit,
  // buffers and fifo
  input wire logic [NUM_RX-1:0] rx_iflag,
  input wire logic [NUM_RX-1:0] rx_ienable,
  input wire logic fifo_received,
  input wire logic [NUM_TX-1:0] tx_iflag,
  input wire logic [NUM_TX-1:0] tx_ienable,
  input wire logic fifo_not_empty,
  input wire logic buf0_locked,
  input wire logic fifo_overrun,
  // other sources
  input wire logic [15:0] host_interface_error_register,
  input wire logic guardian_error,
  input wire logic [NUM_SSC-1:0] ssc_increment,
  // outputs
  output logic irq,
  output pei_level_e level_out,
  output logic force_red
);
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] enable;
    logic [3:0] max_odd;
    pei_timer_s [1:0] timer;
    logic [NUM_SSC-1:0] ssc_mask;
    pei_level_e level;
    logic fatal_red;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pei_st_s;
  pei_st_s st_q;
  pei_st_s st_d;
  logic [3:0] odd_window_fail_count;
  logic [1:0] tim_hit;
  logic [15:0] hw_set;
  logic [15:0] persist;
  logic [15:0] host_clr;
  logic [11:0] widx;
  logic wr_now;
  logic rd_hit;
  logic [31:0] rd_val;
  pei_level_e level_eff;
  pei_level_e level_nxt;
  if (NUM_RX < 1 || NUM_TX < 1 || NUM_SSC < 1 || NUM_SSC > 16) begin : g_bad_count
    $error("pei_status: bad buffer or counter count");
  end
  pei_ccf_counter #(
    .WIDTH(4)
  ) u_ccf (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enter_active(enter_active),
    .cyc(cyc),
    .max_count(st_q.max_odd),
    .count(odd_window_fail_count)
  );
  pei_timer_match #(
    .NUM(2)
  ) u_tim (
    .setup(st_q.timer),
    .cycle_now(cycle_now),
    .mtick_now(mtick_now),
    .hit(tim_hit)
  );
  // register index is byte address divided by four
  assign widx = paddr[13:2];
  // host clears land once, on the edge at which the master sees pready high
  assign wr_now = psel && penable && pwrite && st_q.ready && pstrb[0] && pstrb[1];
  assign level_eff = st_q.fatal_red ? PEI_RED : level_in;
  // a fatal stop changes the level in the same cycle, so it must count as a change
  assign level_nxt = illegal_state ? PEI_RED : level_eff;
  always_comb begin
    hw_set = '0;
    persist = '0;
    hw_set[`PEI_BIT_RX] = |(rx_iflag & rx_ienable) || fifo_received;
    hw_set[`PEI_BIT_TX] = |(tx_iflag & tx_ienable);
    hw_set[`PEI_BIT_HIE] = |host_interface_error_register;
    // fifo flag held until empty and buffer 0 released
    hw_set[`PEI_BIT_FNE] = fifo_not_empty || (st_q.status[`PEI_BIT_FNE] && buf0_locked);
    hw_set[`PEI_BIT_FOV] = fifo_overrun;
    hw_set[`PEI_BIT_CYC] = cycle_start;
    hw_set[`PEI_BIT_TIM0] = tim_hit[0];
    hw_set[`PEI_BIT_TIM1] = tim_hit[1];
    hw_set[`PEI_BIT_MOC] = cyc.cycle_end && cyc.missing_offset;
    hw_set[`PEI_BIT_BGS] = guardian_error;
    hw_set[`PEI_BIT_SSI] = |(ssc_increment & st_q.ssc_mask);
    hw_set[`PEI_BIT_MRC] = cyc.cycle_end && cyc.odd_cycle && cyc.missing_rate;
    hw_set[`PEI_BIT_ELC] = level_nxt != st_q.level;
    hw_set[`PEI_BIT_MSY] = sync_overflow;
    hw_set[`PEI_BIT_CLR] = corr_limit;
    hw_set[`PEI_BIT_FAT] = illegal_state;
    persist = hw_set & `PEI_PERSIST_MASK;
  end
  always_comb begin
    host_clr = '0;
    if (wr_now && widx == `PEI_IDX_STATUS) begin
      host_clr = pwdata[15:0];
    end
    // transmit flag cannot be cleared by the host at all
    host_clr[`PEI_BIT_TX] = 1'b0;
  end
  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    case (widx)
      `PEI_IDX_STATUS: rd_val[15:0] = st_q.status;
      `PEI_IDX_ENABLE: rd_val[15:0] = st_q.enable;
      `PEI_IDX_CCFC: rd_val[3:0] = odd_window_fail_count;
      `PEI_IDX_EHL: rd_val[1:0] = st_q.level;
      `PEI_IDX_MAXODD: rd_val[3:0] = st_q.max_odd;
      `PEI_IDX_TIMER0: rd_val[25:0] = st_q.timer[0];
      `PEI_IDX_TIMER1: rd_val[25:0] = st_q.timer[1];
      `PEI_IDX_CTRL: rd_val[NUM_SSC-1:0] = st_q.ssc_mask;
      default: rd_hit = 1'b0;
    endcase
  end
  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b0;
    st_d.err = 1'b0;
    // device sets are applied after host clears, so sets win
    st_d.status = (st_q.status & ~host_clr) | hw_set | persist;
    // read-only transmit flag tracks its buffers, or it could never fall again
    st_d.status[`PEI_BIT_TX] = hw_set[`PEI_BIT_TX];
    if (leave_config) begin
      st_d.status = `PEI_STATUS_RST;
    end
    st_d.level = level_nxt;
    if (illegal_state) begin
      st_d.fatal_red = 1'b1;
      st_d.level = PEI_RED;
    end
    if (enter_active) begin
      st_d.fatal_red = 1'b0;
    end
    // one wait state: pready rises one edge after the first access edge
    if (psel && penable && !st_q.ready) begin
      st_d.ready = 1'b1;
      st_d.err = !rd_hit;
      st_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
    end
    // writes land on the edge at which the master sees pready high
    if (psel && penable && st_q.ready && pwrite && rd_hit) begin
      case (widx)
        `PEI_IDX_ENABLE: st_d.enable = pwdata[15:0];
        `PEI_IDX_MAXODD: st_d.max_odd = pwdata[3:0];
        `PEI_IDX_TIMER0: st_d.timer[0] = pwdata[25:0];
        `PEI_IDX_TIMER1: st_d.timer[1] = pwdata[25:0];
        `PEI_IDX_CTRL: st_d.ssc_mask = pwdata[NUM_SSC-1:0];
        default: st_d.err = 1'b0;
      endcase
    end
    st_d.irq = |(st_d.status & st_d.enable);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.max_odd <= `PEI_MAXODD_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign irq = st_q.irq;
  assign level_out = st_q.level;
  assign force_red = st_q.fatal_red;
endmodule

// *** pei_status_chk_sva.sv ***
// assertion checker watching the status block's ports
`timescale 1ns/1ps
module pei_status_chk import pei_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // engine and outputs
  input wire logic leave_config,
  input wire logic illegal_state,
  input wire logic irq,
  input wire pei_level_e level_out,
  input wire logic force_red
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  ready_delay_a: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer one cycle after access");
  ready_idle_a: assert property (!(psel && penable) |=> !pready)
    else $error("answer without access");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer not clean");
  fatal_red_a: assert property (illegal_state |=> force_red && level_out == PEI_RED)
    else $error("illegal state did not force red");
  cfg_clear_a: assert property (leave_config |=> !irq)
    else $error("irq survived config exit");
  // the two timer words are wider than the sixteen-bit status words
  upper_zero_a: assert property (pready && !pwrite && paddr != 14'hCB0 && paddr != 14'hCB8
      |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  count_bits_a: assert property (pready && !pwrite && paddr == 14'hC98 |-> prdata[15:4] == 12'h0)
    else $error("counter reserved bits set");
endmodule

bind pei_status pei_status_chk u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .leave_config(leave_config),
  .illegal_state(illegal_state),
  .irq(irq),
  .level_out(level_out),
  .force_red(force_red)
);

// *** pei_host.sv ***
// apb master model standing in for the host processor
`timescale 1ns/1ps
module pei_host (
  // clock
  input wire logic clock,
  // apb master
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [13:0] paddr = 14'h0000,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // a write of ones to status is how the host clears flags
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data flips so a stale value cannot pass
    pwdata <= ~d;
  endtask
endmodule

// *** tb.sv ***
// self-checking bench for the protocol error status block
`timescale 1ns/1ps
`include "pei_map.svh"
module tb import pei_pkg::*; ;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic buf0_locked = 1'b0;
  logic fifo_received = 1'b0;
  logic [5:0] cycle_now = 6'h00;
  logic [13:0] mtick_now = 14'h0000;
  logic [8:0] ev = 9'h000;
  logic [3:0] cause = 4'h0;
  logic [7:0] buf_en = 8'h00;
  pei_level_e level_in = PEI_GREEN;
  pei_cycle_s cyc = '0;
  wire logic psel, penable, pwrite, pready, pslverr, irq, force_red;
  wire logic [13:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [3:0] pstrb;
  wire pei_level_e level_out;
  wire logic sync_overflow = ev[0];
  wire logic corr_limit = ev[1];
  wire logic fifo_overrun = ev[2];
  wire logic cycle_start = ev[3];
  wire logic guardian_error = ev[4];
  wire logic [7:0] ssc_increment = {7'h00, ev[5]};
  wire logic illegal_state = ev[6];
  wire logic enter_active = ev[7];
  wire logic leave_config = ev[8];
  wire logic [7:0] rx_iflag = {7'h00, cause[0]};
  wire logic [7:0] tx_iflag = {7'h00, cause[1]};
  wire logic [7:0] rx_ienable = buf_en;
  wire logic [7:0] tx_ienable = buf_en;
  wire logic [15:0] host_interface_error_register = {15'h0000, cause[2]};
  wire logic fifo_not_empty = cause[3];
  int bad_count = 0;
  int total_checks = 0;
  logic [31:0] rdat;
  logic rerr;
  localparam logic [13:0] A_ST = {`PEI_IDX_STATUS, 2'b00};
  localparam logic [13:0] A_EN = {`PEI_IDX_ENABLE, 2'b00};
  localparam logic [13:0] A_CNT = {`PEI_IDX_CCFC, 2'b00};
  localparam logic [13:0] A_LVL = {`PEI_IDX_EHL, 2'b00};
  localparam logic [13:0] A_MAX = {`PEI_IDX_MAXODD, 2'b00};
  localparam logic [13:0] A_T0 = {`PEI_IDX_TIMER0, 2'b00};
  localparam logic [13:0] A_MSK = {`PEI_IDX_CTRL, 2'b00};
  // fatal also moves the level, so its entry carries the change flag
  localparam logic [15:0] EV_BIT [7] = '{16'h2000, 16'h4000, 16'h0010, 16'h0020,
    16'h0200, 16'h0400, 16'h9000};

  pei_status DUT (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .leave_config(leave_config),
    .enter_active(enter_active),
    .level_in(level_in),
    .illegal_state(illegal_state),
    .cyc(cyc),
    .cycle_start(cycle_start),
    .cycle_now(cycle_now),
    .mtick_now(mtick_now),
    .sync_overflow(sync_overflow),
    .corr_limit(corr_limit),
    .rx_iflag(rx_iflag),
    .rx_ienable(rx_ienable),
    .fifo_received(fifo_received),
    .tx_iflag(tx_iflag),
    .tx_ienable(tx_ienable),
    .fifo_not_empty(fifo_not_empty),
    .buf0_locked(buf0_locked),
    .fifo_overrun(fifo_overrun),
    .host_interface_error_register(host_interface_error_register),
    .guardian_error(guardian_error),
    .ssc_increment(ssc_increment),
    .irq(irq),
    .level_out(level_out),
    .force_red(force_red)
  );
  pei_host host (
    .clock(clock),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input string name, input logic [13:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rdat, rerr);
    check(name, rdat, exp);
  endtask

  task automatic pulse(input int n);
    @(posedge clock);
    ev <= 9'h001 << n;
    @(posedge clock);
    ev <= 9'h000;
    @(negedge clock);
  endtask

  task automatic pulse_cyc(input logic [3:0] c);
    @(posedge clock);
    cyc <= c;
    @(posedge clock);
    cyc <= '0;
  endtask

  task automatic give_verdict;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd("status after reset", A_ST, 32'h00C0);
    check("irq after reset", {31'h0, irq}, 32'h0);
    rd("unmapped", 14'h0004, 32'h0);
    check("unmapped error", {31'h0, rerr}, 32'h1);
    $display("test reset done");
    mtick_now <= 14'h0001;
    wr(A_ST, 32'hFFFF);
    rd("status cleared", A_ST, 32'h0);
    wr(A_MAX, 32'h2);
    for (int i = 1; i <= 3; i++) begin
      pulse_cyc(4'hE);
      rd("count", A_CNT, (i > 2) ? 32'h2 : 32'(i));
    end
    wr(A_CNT, 32'hFFFF);
    rd("count read only", A_CNT, 32'h2);
    pulse_cyc(4'hC);
    rd("count zeroed", A_CNT, 32'h0);
    pulse_cyc(4'hD);
    rd("count on rate", A_CNT, 32'h1);
    rd("rate flag", A_ST, 32'h0900);
    pulse(7);
    rd("count on active", A_CNT, 32'h0);
    wr(A_ST, 32'hFFFF);
    pulse_cyc(4'hA);
    rd("even offset flag", A_ST, 32'h0100);
    $display("test counter done");
    cause <= 4'hF;
    wr(A_ST, 32'hFFFF);
    rd("unenabled buffers", A_ST, 32'h000C);
    buf_en <= 8'h01;
    wr(A_ST, 32'h000F);
    rd("causes hold flags", A_ST, 32'h000F);
    cause <= 4'h0;
    wr(A_ST, 32'h000F);
    rd("causes resolved", A_ST, 32'h0);
    cause <= 4'h8;
    buf0_locked <= 1'b1;
    fifo_received <= 1'b1;
    rd("fifo set", A_ST, 32'h0009);
    cause <= 4'h0;
    fifo_received <= 1'b0;
    wr(A_ST, 32'h0009);
    rd("fifo held by lock", A_ST, 32'h0008);
    buf0_locked <= 1'b0;
    wr(A_ST, 32'h0008);
    rd("fifo released", A_ST, 32'h0);
    $display("test persistent done");
    wr(A_T0, 32'h005F_C010);
    cycle_now <= 6'h05;
    mtick_now <= 14'h0010;
    rd("timer match", A_ST, 32'h0040);
    cycle_now <= 6'h04;
    wr(A_ST, 32'hFFFF);
    rd("timer cycle miss", A_ST, 32'h0);
    mtick_now <= 14'h0001;
    $display("test timer done");
    level_in <= PEI_YELLOW;
    rd("level", A_LVL, 32'h1);
    rd("level change", A_ST, 32'h1000);
    wr(A_MSK, 32'hFF);
    for (int i = 0; i < 7; i++) begin
      wr(A_ST, 32'hFFFF);
      pulse(i);
      rd("event flag", A_ST, {16'h0, EV_BIT[i]});
    end
    rd("level red", A_LVL, 32'h2);
    check("force red", {31'h0, force_red}, 32'h1);
    check("level out red", {30'h0, level_out}, 32'h2);
    $display("test events done");
    pulse(7);
    wr(A_ST, 32'hFFFF);
    check("force red released", {31'h0, force_red}, 32'h0);
    check("level out back", {30'h0, level_out}, 32'h1);
    wr(A_EN, 32'h0020);
    check("irq idle", {31'h0, irq}, 32'h0);
    clk_en <= 1'b0;
    pulse(3);
    @(posedge clock);
    clk_en <= 1'b1;
    check("irq frozen", {31'h0, irq}, 32'h0);
    pulse(3);
    check("irq raised", {31'h0, irq}, 32'h1);
    pulse(8);
    rd("config exit", A_ST, 32'h0);
    check("irq config exit", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    give_verdict();
  end
endmodule
